// *** src/sdsr_readout.sv ***
/*
 * Serial readout port: buffers conversion results, codes them and
 * shifts them out MSB first under chip select and word ready.
 * Assumes pins are synchronous to clk_sys; the link is joined outside
 * from the data, clock and enable signals.
 */
`timescale 1ns/1ps
module sdsr_readout
    import sdsr_pkg::*;
#(
    parameter int DEPTH = SDSR_FIFO_DEPTH
)
(
    input wire logic clk_sys,                  // Master clock, 100 MHz
    input wire logic rst_n,                    // Async reset, low
    input wire logic conv_valid,               // New result offered
    output logic conv_ready,                   // Buffer takes result
    input wire logic [SDSR_WORD_W-1:0] conv_data, // Two's complement
    input wire logic polarity_select,          // High bipolar
    input wire logic self_clocking_mode,       // High self clocked
    input wire logic cs_n,                     // Chip select, low
    input wire logic sclk_in,                  // Host serial clock
    output logic sclk_out,                     // Self serial clock
    output logic sclk_oe,                      // Drives serial clock
    output logic serial_data_out,              // Serial data
    output logic serial_data_oe,               // Drives serial data
    output logic word_ready_n,                 // Word waiting, low
    input wire logic cal_in,                   // Calibrate strobe
    input wire logic cal_select_a,             // Calibration select a
    input wire logic cal_select_b,             // Calibration select b
    output logic cal_reset,                    // Held in reset by strobe
    output logic cal_start,                    // Calibration begins
    output logic [1:0] cal_type,               // Latched selects b,a
    output logic system_cal                    // System calibration
);

    // Output coding of a two's complement result
    function automatic logic [SDSR_WORD_W-1:0] sdsr_code(
        input logic [SDSR_WORD_W-1:0] raw,
        input logic bipolar
    );
        logic [SDSR_WORD_W-1:0] res;
        res = '0;
        if (bipolar)
        begin
            res = {~raw[SDSR_WORD_W-1], raw[SDSR_WORD_W-2:0]};
        end
        else if (!raw[SDSR_WORD_W-1])
        begin
            res = {raw[SDSR_WORD_W-2:0], &raw[SDSR_WORD_W-2:0]};
        end
        return res;
    endfunction : sdsr_code

    sdsr_state_type state_q;                   // Sequencer state
    logic [SDSR_WORD_W-1:0] hold_q;            // Word under readout
    logic hold_valid_q;                        // Word waiting
    logic [4:0] bit_q;                         // Index of bit on line
    logic stop_q;                              // Deselect seen mid word
    logic ssc_q;                               // Mode caught at start
    logic [1:0] phase_q;                       // Self clock phase
    logic sclk_q;                              // Self clock level
    logic sclk_prev_q;                         // Host clock last cycle
    logic sdo_q;                               // Data bit
    logic oe_q;                                // Driving the link
    logic [2:0] blank_q;                       // Blank countdown
    logic [2:0] cal_cnt_q;                     // Strobe high length
    logic cal_prev_q;                          // Strobe last cycle
    logic [1:0] cal_type_q;                    // Latched selects
    logic cal_start_q;                         // Start pulse
    logic fifo_valid;                          // Buffer head present
    logic fifo_take;                           // Head into hold reg
    logic [SDSR_WORD_W-1:0] fifo_data;         // Buffer head
    logic armed;                               // Strobe long enough
    logic begin_shift;                         // Select recognised
    logic adv;                                 // Bit boundary

    ////////////////////////////////////////////////////////////////////
    // Result buffer
    sdsr_fifo #(
        .WIDTH(SDSR_WORD_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_valid(conv_valid),
        .in_ready(conv_ready),
        .in_data(conv_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_take),
        .out_data(fifo_data)
    );

    ////////////////////////////////////////////////////////////////////
    // Combinational control terms
    assign armed = (cal_cnt_q > 3'(SDSR_CAL_HOLD_CYC));
    // Newer result replaces a word not yet being read
    assign fifo_take = (state_q == SDSR_IDLE) && !armed;
    // Select accepted only while a word waits, not in blank
    assign begin_shift = (state_q == SDSR_IDLE) && hold_valid_q
        && !cs_n && !armed && !fifo_valid;
    // Self clock falls after phase high; host clock on falling edge
    assign adv = ssc_q ? (phase_q == SDSR_PHASE_HIGH)
        : (sclk_prev_q && !sclk_in);
    assign word_ready_n = !hold_valid_q;
    assign serial_data_out = sdo_q;
    assign serial_data_oe = oe_q;
    assign sclk_out = sclk_q;
    assign sclk_oe = oe_q && ssc_q;
    assign cal_reset = armed;
    assign cal_start = cal_start_q;
    assign cal_type = cal_type_q;
    assign system_cal = !cal_type_q[1];

    ////////////////////////////////////////////////////////////////////
    // Hold register and ready flag
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hold_q <= '0;
            hold_valid_q <= 1'b0;
        end
        else if (armed)
        begin
            hold_valid_q <= 1'b0;
        end
        else if (fifo_take && fifo_valid)
        begin
            hold_q <= sdsr_code(fifo_data, polarity_select);
            hold_valid_q <= 1'b1;
        end
        else if (state_q == SDSR_SHIFT && adv && !stop_q
            && bit_q == '0)
        begin
            hold_valid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Readout sequencer
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= SDSR_IDLE;
            bit_q <= '0;
            stop_q <= 1'b0;
            ssc_q <= 1'b0;
            sdo_q <= 1'b0;
            oe_q <= 1'b0;
            blank_q <= '0;
        end
        else if (armed)
        begin
            state_q <= SDSR_IDLE;
            oe_q <= 1'b0;
            stop_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                SDSR_IDLE:
                begin
                    if (begin_shift)
                    begin
                        state_q <= SDSR_SHIFT;
                        bit_q <= SDSR_MSB_IDX;
                        sdo_q <= hold_q[SDSR_MSB_IDX];
                        oe_q <= 1'b1;
                        stop_q <= 1'b0;
                        ssc_q <= self_clocking_mode;
                    end
                end
                SDSR_SHIFT:
                begin
                    if (cs_n)
                    begin
                        stop_q <= 1'b1;
                    end
                    if (adv)
                    begin
                        if (stop_q || cs_n)
                        begin
                            // Current bit done; release the link
                            state_q <= SDSR_IDLE;
                            oe_q <= 1'b0;
                        end
                        else if (bit_q == '0)
                        begin
                            state_q <= SDSR_BLANK;
                            oe_q <= 1'b0;
                            blank_q <= 3'(SDSR_BLANK_CYC - 1);
                        end
                        else
                        begin
                            bit_q <= bit_q - 1'b1;
                            sdo_q <= hold_q[bit_q - 1'b1];
                        end
                    end
                end
                SDSR_BLANK:
                begin
                    // Ready stays high, select is not looked at
                    if (blank_q == '0)
                    begin
                        state_q <= SDSR_IDLE;
                    end
                    else
                    begin
                        blank_q <= blank_q - 1'b1;
                    end
                end
                default:
                begin
                    state_q <= SDSR_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Serial clock: self divider and host clock history
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase_q <= '0;
            sclk_q <= 1'b0;
            sclk_prev_q <= 1'b0;
        end
        else
        begin
            sclk_prev_q <= sclk_in;
            if (begin_shift)
            begin
                phase_q <= SDSR_PHASE_START;
                sclk_q <= 1'b0;
            end
            else if (state_q == SDSR_SHIFT && ssc_q && !armed)
            begin
                // One high phase in four: divide by four, 25% duty
                phase_q <= phase_q + 1'b1;
                sclk_q <= (phase_q == 2'h3) && !adv;
            end
            else
            begin
                sclk_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Calibration strobe watch
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cal_cnt_q <= '0;
            cal_prev_q <= 1'b0;
            cal_type_q <= 2'h3;
            cal_start_q <= 1'b0;
        end
        else
        begin
            cal_prev_q <= cal_in;
            cal_start_q <= 1'b0;
            if (cal_in && !cal_prev_q)
            begin
                cal_type_q <= {cal_select_b, cal_select_a};
            end
            if (cal_in)
            begin
                if (!armed)
                begin
                    cal_cnt_q <= cal_cnt_q + 1'b1;
                end
            end
            else
            begin
                cal_start_q <= armed;
                cal_cnt_q <= '0;
            end
        end
    end

endmodule : sdsr_readout

// *** src/sdsr_pkg.sv ***
/*
 * Shared constants for the sigma-delta serial readout port.
 * Assumes a single 100 MHz system clock and synchronous pin inputs.
 */
package sdsr_pkg;

    localparam int SDSR_WORD_W = 20;           // Conversion word width
    localparam int SDSR_FIFO_DEPTH = 32;       // Result buffer depth
    localparam int SDSR_CLK_NS = 10;           // System clock period
    localparam int SDSR_CS_RECOG_NS = 160;     // Extra chip-select delay
    // Longest recognition delay: four clocks plus 160 ns, rounded down
    localparam int SDSR_CS_RECOG_CYC = 4 + SDSR_CS_RECOG_NS / SDSR_CLK_NS;
    localparam int SDSR_BLANK_CYC = 4;         // Ready held high after word
    localparam int SDSR_CAL_HOLD_CYC = 4;      // Calibrate strobe length
    localparam logic [4:0] SDSR_MSB_IDX = 5'h13; // First bit sent
    localparam logic [1:0] SDSR_PHASE_START = 2'h1; // Self clock phase
    localparam logic [1:0] SDSR_PHASE_HIGH = 2'h0;  // Serial clock high

    // Readout sequencer states
    typedef enum logic [1:0] {
        SDSR_IDLE = 2'b00,
        SDSR_SHIFT = 2'b01,
        SDSR_BLANK = 2'b10
    } sdsr_state_type;

endpackage : sdsr_pkg

// *** src/sdsr_fifo.sv ***
/*
 * Result buffer: synchronous FIFO with a registered output stage.
 * Assumes one clock; depth must be a power of two of at least two.
 */
`timescale 1ns/1ps
module sdsr_fifo
    import sdsr_pkg::*;
#(
    parameter int WIDTH = SDSR_WORD_W,
    parameter int DEPTH = SDSR_FIFO_DEPTH
)
(
    input wire logic clk_sys,                  // System clock
    input wire logic rst_n,                    // Async reset, low
    input wire logic in_valid,                 // Fill side offers word
    output logic in_ready,                     // Fill side may push
    input wire logic [WIDTH-1:0] in_data,      // Fill side word
    output logic out_valid,                    // Head word present
    input wire logic out_ready,                // Drain side takes head
    output logic [WIDTH-1:0] out_data          // Head word, registered
);

    localparam int AW = $clog2(DEPTH);

    // Refuse shapes the pointer logic cannot serve
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("sdsr_fifo depth must be a power of two");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];           // Storage array
    logic [AW-1:0] wr_ptr_q;                   // Write pointer
    logic [AW-1:0] rd_ptr_q;                   // Read pointer
    logic [AW:0] cnt_q;                        // Words in array
    logic out_valid_q;                         // Output stage full
    logic [WIDTH-1:0] out_data_q;              // Output stage word
    logic push;                                // Word accepted
    logic load;                                // Array to output stage

    ////////////////////////////////////////////////////////////////////
    // Handshake terms
    assign in_ready = (cnt_q != (AW + 1)'(DEPTH));
    assign push = in_valid && in_ready;
    assign load = (cnt_q != '0) && (!out_valid_q || out_ready);
    assign out_valid = out_valid_q;
    assign out_data = out_data_q;

    ////////////////////////////////////////////////////////////////////
    // Storage writes
    always_ff @(posedge clk_sys)
    begin
        if (push)
        begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    // Pointers and count
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (load)
            begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(load);
        end
    end

    // Registered output stage
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_valid_q <= 1'b0;
            out_data_q <= '0;
        end
        else if (load)
        begin
            out_valid_q <= 1'b1;
            out_data_q <= mem_q[rd_ptr_q];
        end
        else if (out_ready)
        begin
            out_valid_q <= 1'b0;
        end
    end

endmodule : sdsr_fifo

// *** sim/sdsr_readout_assertions.sv ***
/* Checker for the serial readout port.
   Bound into sdsr_readout; sees its ports only. */
`timescale 1ns/1ps
module sdsr_readout_assertions
(
    input wire logic clk_sys, // Clock
    input wire logic rst_n, // Reset, low
    input wire logic self_clocking_mode, // Self clocked
    input wire logic cs_n, // Chip select
    input wire logic sclk_in, // Host clock
    input wire logic sclk_out, // Device clock
    input wire logic sclk_oe, // Device clock enable
    input wire logic serial_data_out, // Data bit
    input wire logic serial_data_oe, // Data enable
    input wire logic word_ready_n, // Word waiting
    input wire logic cal_in, // Calibrate strobe
    input wire logic cal_select_a, // Calibration select a
    input wire logic cal_select_b, // Calibration select b
    input wire logic cal_reset, // Held in reset
    input wire logic cal_start, // Calibration begins
    input wire logic [1:0] cal_type, // Latched selects
    input wire logic system_cal // System calibration
);
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////
    chk_oe_after_select:
        assert property ($rose(serial_data_oe) |->
            !$past(word_ready_n) && !$past(cs_n))
        else $error("data driven without select and word");
    chk_blank_quiet:
        assert property ($rose(word_ready_n) |-> !serial_data_oe [*4])
        else $error("data driven during blank");
    chk_ext_shift_edge:
        assert property (!self_clocking_mode && serial_data_oe &&
            $past(serial_data_oe) && $changed(serial_data_out) |->
            !$past(sclk_in) && $past(sclk_in, 2))
        else $error("data moved without serial clock fall");
    chk_ext_release_edge:
        assert property (!self_clocking_mode && $fell(serial_data_oe) &&
            !cal_reset && !$past(cal_reset) |->
            !$past(sclk_in) && $past(sclk_in, 2))
        else $error("data released off a clock fall");
    chk_self_duty:
        assert property (sclk_out |=> !sclk_out [*3])
        else $error("self clock high too long");
    chk_ext_no_clock:
        assert property (!self_clocking_mode &&
            !$past(self_clocking_mode) |-> !sclk_oe)
        else $error("serial clock driven in external mode");
    chk_cal_reset_long:
        assert property ($rose(cal_reset) |->
            $past(cal_in) && $past(cal_in, 4))
        else $error("calibrate reset after short strobe");
    chk_cal_reset_drop:
        assert property (!$past(cal_in) && !$past(cal_in, 2) |-> !cal_reset)
        else $error("calibrate reset outlasts strobe");
    chk_cal_start_fall:
        assert property (cal_start |-> !$past(cal_in) &&
            ($past(cal_in, 2) || $past(cal_in, 3)) ##1 !cal_start)
        else $error("calibration start off strobe release");
    chk_sys_cal_sel:
        assert property (system_cal == !cal_type[1])
        else $error("system calibration not from select b");
    // Worst select recognition: four clocks plus 160 ns at 10 ns
    localparam int RECOG_MAX = 20;
    chk_select_recog:
        assert property ($fell(cs_n) && !word_ready_n && !cal_reset |->
            ##[1:RECOG_MAX] serial_data_oe)
        else $error("select with word waiting not recognised in time");
    chk_cal_sel_latch:
        assert property ($rose(cal_in) |=>
            cal_type == {$past(cal_select_b), $past(cal_select_a)})
        else $error("calibration type not latched at strobe rise");
endmodule : sdsr_readout_assertions

bind sdsr_readout sdsr_readout_assertions sdsr_readout_assertions_inst
(
    .clk_sys, .rst_n, .self_clocking_mode, .cs_n, .sclk_in, .sclk_out,
    .sclk_oe, .serial_data_out, .serial_data_oe, .word_ready_n, .cal_in,
    .cal_select_a, .cal_select_b,
    .cal_reset, .cal_start, .cal_type, .system_cal
);

// *** sim/sdsr_host_model.sv ***
/* Host serial port model: selects the device, clocks a word out.
   Assumes a pull-up on the data wire; driven at falling edges. */
`timescale 1ns/1ps
module sdsr_host_model
    import sdsr_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic self_mode, // Device makes the clock
    input wire logic serial_data_out, // Device data
    input wire logic serial_data_oe, // Device drives data
    input wire logic sclk_out, // Device serial clock
    output logic cs_n, // Chip select, low
    output logic sclk_in // Host serial clock
);
    logic line; // Data wire seen by host
    // Released wire floats up to the pull-up
    assign line = serial_data_oe ? serial_data_out : 1'b1;
    // Idle: deselected, clock parked low
    initial
    begin
        cs_n = 1'b1;
        sclk_in = 1'b0;
    end
    task automatic gap(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : gap
    // One frame of nbits, MSB first; short frame aborts
    task automatic xfer(input int nbits, output logic [19:0] w);
        int k;
        w = 20'h00000;
        cs_n = 1'b0;
        if (!self_mode)
            gap(SDSR_CS_RECOG_CYC);
        for (int i = 0; i < nbits; i++)
        begin
            if (self_mode)
            begin
                k = 0;
                while (sclk_out !== 1'b1 && k < 40)
                begin
                    gap(1);
                    k++;
                end
                w = {w[18:0], line}; // Take bit while clock high
                gap(1);
            end
            else
            begin
                sclk_in = 1'b1; // Take bit on the rise
                w = {w[18:0], line};
                gap(2);
                sclk_in = 1'b0; // Device moves data on the fall
                gap(2);
            end
        end
        cs_n = 1'b1;
        if (nbits < 20 && !self_mode)
        begin
            sclk_in = 1'b1; // One more fall ends the bit
            gap(2);
            sclk_in = 1'b0;
        end
        gap(2);
    endtask : xfer
endmodule : sdsr_host_model

// *** sim/sdsr_readout_tb.sv ***
/* Testbench for the serial readout port.
   Inputs change at falling edges; host model reads the words. */
`timescale 1ns/1ps
module sdsr_readout_tb
    import sdsr_pkg::*;
;
    logic clk_sys = 1'b0; // System clock
    logic rst_n = 1'b0; // Reset, low
    logic conv_valid = 1'b0; // Word offered
    logic [SDSR_WORD_W-1:0] conv_data = 20'h00000; // Word
    logic polarity_select = 1'b0; // Bipolar
    logic self_clocking_mode = 1'b0; // Self clocked
    logic cal_in = 1'b0; // Calibrate strobe
    logic cal_select_a = 1'b1; // Select a
    logic cal_select_b = 1'b1; // Select b
    logic cs_n, sclk_in, sclk_out, sclk_oe; // Link pins
    logic serial_data_out, serial_data_oe, word_ready_n; // Data pins
    logic conv_ready, cal_reset, cal_start, system_cal; // Status
    logic [1:0] cal_type; // Latched selects
    int num_errors = 0; // Mismatches
    int tests_run = 0; // Comparisons
    always #5 clk_sys = ~clk_sys;
    sdsr_readout sdsr_readout_inst
    (
        .clk_sys, .rst_n, .conv_valid, .conv_ready, .conv_data,
        .polarity_select, .self_clocking_mode, .cs_n, .sclk_in,
        .sclk_out, .sclk_oe, .serial_data_out, .serial_data_oe,
        .word_ready_n, .cal_in, .cal_select_a, .cal_select_b,
        .cal_reset, .cal_start, .cal_type, .system_cal
    );
    sdsr_host_model sdsr_host_model_inst
    (
        .clk_sys, .self_mode(self_clocking_mode), .serial_data_out,
        .serial_data_oe, .sclk_out, .cs_n, .sclk_in
    );
    ////////////////////////////////////////////////////////////////////
    // Expected output word for a raw result
    function automatic logic [19:0] code(logic [19:0] r, logic bp);
        if (bp)
            return {~r[19], r[18:0]};
        return r[19] ? 20'h00000 : {r[18:0], &r[18:0]};
    endfunction : code
    task automatic chk_w(input logic [19:0] g, input logic [19:0] e);
        tests_run++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD %0t word %h expected %h", $time, g, e);
        end
    endtask : chk_w
    task automatic chk_b(input logic g, input logic e);
        tests_run++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD %0t bit %b expected %b", $time, g, e);
        end
    endtask : chk_b
    task automatic summarize;
        if (num_errors == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize
    task automatic gap(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : gap
    // Offer one word, wait until the buffer takes it
    task automatic push(input logic [19:0] d);
        int k;
        k = 0;
        conv_valid = 1'b1;
        conv_data = d;
        while (conv_ready !== 1'b1 && k < 100)
        begin
            gap(1);
            k++;
        end
        chk_b(conv_ready, 1'b1); // A refused word is a mismatch
        gap(1);
        conv_valid = 1'b0;
    endtask : push
    task automatic wait_word;
        int k;
        k = 0;
        while (word_ready_n !== 1'b0 && k < 300)
        begin
            gap(1);
            k++;
        end
        chk_b(word_ready_n, 1'b0);
    endtask : wait_word
    ////////////////////////////////////////////////////////////////////
    // Every mode and coding at boundary values
    task automatic t_coding;
        logic [19:0] v [4] = '{20'h00000, 20'h7ffff, 20'h80000, 20'h12345};
        logic [19:0] w;
        for (int m = 0; m < 4; m++)
            for (int i = 0; i < 4; i++)
            begin
                self_clocking_mode = m[1];
                polarity_select = m[0];
                push(v[i]);
                wait_word();
                sdsr_host_model_inst.xfer(20, w);
                chk_w(w, code(v[i], m[0]));
                gap(2);
                chk_b(word_ready_n, 1'b1);
            end
    endtask : t_coding
    // Early deselect in both clock modes, then full re-read
    task automatic t_abort;
        logic [19:0] w;
        for (int m = 0; m < 2; m++)
        begin
            self_clocking_mode = m[0];
            push(20'h5a3c9);
            wait_word();
            sdsr_host_model_inst.xfer(7, w);
            gap(4);
            chk_b(serial_data_oe, 1'b0);
            chk_b(sclk_oe, 1'b0);
            chk_b(word_ready_n, 1'b0);
            sdsr_host_model_inst.xfer(20, w);
            chk_w(w, code(20'h5a3c9, polarity_select));
        end
    endtask : t_abort
    // Select with no word waiting is ignored
    task automatic t_refuse;
        sdsr_host_model_inst.cs_n = 1'b0;
        gap(8);
        chk_b(serial_data_oe, 1'b0);
        sdsr_host_model_inst.cs_n = 1'b1;
        gap(1);
    endtask : t_refuse
    // Fill the buffer during a read, then drain to the newest word
    task automatic t_fill;
        logic [19:0] w;
        logic ok;
        logic full;
        int n;
        n = 0;
        full = 1'b0;
        self_clocking_mode = 1'b0;
        polarity_select = 1'b0;
        push(20'h2468a);
        wait_word();
        fork
            sdsr_host_model_inst.xfer(20, w);
            begin
                gap(30);
                conv_valid = 1'b1;
                repeat (60)
                begin
                    conv_data = 20'h40000 | 20'(n);
                    ok = conv_ready;
                    gap(1);
                    if (ok === 1'b1)
                        n++;
                    else
                        full = 1'b1;
                end
                conv_valid = 1'b0;
            end
        join
        chk_w(w, code(20'h2468a, 1'b0));
        chk_b(full, 1'b1);
        gap(200);
        wait_word();
        sdsr_host_model_inst.xfer(20, w);
        chk_w(w, code(20'h40000 | 20'(n - 1), 1'b0));
    endtask : t_fill
    // All select pairs with long strobe, then one short strobe
    task automatic t_cal;
        int c;
        for (int s = 0; s < 5; s++)
        begin
            cal_select_a = s[0];
            cal_select_b = s[1];
            gap(1);
            cal_in = 1'b1;
            gap(s == 4 ? 3 : 7);
            chk_b(cal_reset, s != 4);
            cal_in = 1'b0;
            c = 0;
            repeat (6)
            begin
                gap(1);
                c += cal_start;
            end
            chk_b(c == (s != 4), 1'b1);
            chk_b(cal_type[0], s[0]);
            chk_b(system_cal, !s[1]);
        end
    endtask : t_cal
    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        gap(2);
        rst_n = 1'b1;
        chk_b(word_ready_n, 1'b1);
        chk_b(serial_data_oe, 1'b0);
        chk_b(conv_ready, 1'b1);
        chk_b(system_cal, 1'b0);
        t_coding();
        t_abort();
        t_refuse();
        t_fill();
        t_cal();
        summarize();
    end
    // Watchdog: about eight times the expected run of some 2500 cycles
    initial
    begin
        #200000;
        num_errors++;
        summarize();
    end
endmodule : sdsr_readout_tb
